// [logic/ldps_ctrl.sv]
// led dimming and ambient light control with a write-only two-wire slave port
module ldps_ctrl
    import ldps_pkg::*;
#(
    parameter int RAMP_LSB_CYC = RAMP_LSB_CYC_DEF,
    parameter int AMB_BASE_CYC = AMB_BASE_CYC_DEF,
    parameter int PWM_SLOT_CYC = PWM_SLOT_CYC_DEF
) (
    // system
    input  wire logic       clk,
    input  wire logic       resetn,
    // two-wire link
    input  wire logic       scl,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // strap and sensor comparator
    input  wire logic       busAddressStrap,
    input  wire logic       ambientSenseInput,
    // led drive and sensor bias
    output logic [4:0]      ledCurrent,
    output logic            ledEnable,
    output logic [2:0]      segmentPwm,
    output logic            sensorBiasOutput
);

    localparam int PRE_MAX = (RAMP_LSB_CYC > AMB_BASE_CYC) ? RAMP_LSB_CYC : AMB_BASE_CYC;
    localparam int PRE_W   = $clog2(PRE_MAX + 1);
    localparam int PWM_W   = $clog2(PWM_SLOT_CYC + 1);
    localparam logic [PRE_W-1:0] RAMP_LAST = PRE_W'(RAMP_LSB_CYC - 1);
    localparam logic [PRE_W-1:0] AMB_LAST  = PRE_W'(AMB_BASE_CYC - 1);
    localparam logic [PWM_W-1:0] PWM_LAST  = PWM_W'(PWM_SLOT_CYC - 1);

    // ------------------------------------------------------------------
    // state types
    // ------------------------------------------------------------------
    typedef struct packed {
        ldps_phase_t phase;
        logic [3:0]  bitCnt;
        logic [7:0]  shift;
        logic [1:0]  startSync;
        logic        startSeen;
        logic [1:0]  strapSync;
        ldps_wr_t    wr;
        logic        wrTgl;
    } ldps_link_t;

    typedef struct packed {
        logic [1:0]       wrSync;
        logic             wrSeen;
        logic [1:0]       startSync;
        logic             startSeen;
        logic [1:0]       stopSync;
        logic             stopSeen;
        logic [1:0]       ambSync;
        logic             busy;
        logic             run;
        logic [4:0]       maxCode;
        logic [4:0]       upTgt;
        logic [4:0]       dnTgt;
        logic             lastUp;
        logic [4:0]       stepTime;
        logic [2:0][4:0]  duty;
        logic             gainEn;
        logic [4:0]       gain;
        logic [3:0]       floorCode;
        logic [5:0]       ambTime;
        logic [4:0]       code;
        ldps_ramp_t       ramp;
        logic [4:0]       rampTgt;
        logic [PRE_W-1:0] rampPre;
        logic [4:0]       rampUnits;
        logic [PRE_W-1:0] ambPre;
        logic [6:0]       ambUnits;
        logic [PWM_W-1:0] pwmPre;
        logic [4:0]       pwmSlot;
        logic [2:0]       segOut;
        logic             bias;
    } ldps_core_t;

    ldps_link_t lnk_r;
    ldps_link_t lnk_nxt;
    ldps_core_t st_r;
    ldps_core_t st_nxt;
    logic       startTgl_r;
    logic       stopTgl_r;
    logic       ackOe_r;
    logic       ackable;
    logic       wrEvt;
    ldps_wr_t   wrWord;
    logic       ambActive;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [PRE_W-1:0] advanceCount(input logic [PRE_W-1:0] cnt,
                                                     input logic [PRE_W-1:0] last);
        return (cnt == last) ? '0 : cnt + 1'b1;
    endfunction : advanceCount

    // one code toward the target; never wraps past 0 or 1f
    function automatic logic [4:0] stepToward(input logic [4:0] cur, input logic [4:0] tgt);
        if (tgt > cur && cur != CODE_MAX) begin
            return cur + 5'h01;
        end else if (tgt < cur && cur != 5'h00) begin
            return cur - 5'h01;
        end
        return cur;
    endfunction : stepToward

    // lowest set bit wins, so combined bits still give a listed timing
    function automatic logic [5:0] ambMult(input logic [5:0] t);
        logic [5:0] m;
        m = 6'h00;
        for (int i = 5; i >= 0; i--) begin
            if (t[i]) begin
                m = 6'(1 << i);
            end
        end
        return m;
    endfunction : ambMult

    // ------------------------------------------------------------------
    // frame edge detectors on the data line
    // ------------------------------------------------------------------
    // start and stop are the only events that have no clock edge of their own
    always_ff @(negedge sdaIn or negedge resetn) begin
        if (!resetn) begin
            startTgl_r <= 1'b0;
        end else if (scl) begin
            startTgl_r <= ~startTgl_r;
        end
    end

    always_ff @(posedge sdaIn or negedge resetn) begin
        if (!resetn) begin
            stopTgl_r <= 1'b0;
        end else if (scl) begin
            stopTgl_r <= ~stopTgl_r;
        end
    end

    // ------------------------------------------------------------------
    // link domain: byte receiver on the bus clock
    // ------------------------------------------------------------------
    // read direction bit is ignored, so a read frame writes like a write
    always_comb begin
        if (lnk_r.phase == LINK_ADDR) begin
            ackable = lnk_r.shift[7:1] == (lnk_r.strapSync[1] ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW);
        end else begin
            ackable = lnk_r.phase != LINK_IDLE;
        end
    end

    // address, then select/data pairs until stop or a new start
    always_comb begin
        lnk_nxt              = lnk_r;
        lnk_nxt.startSync[0] = startTgl_r;
        lnk_nxt.startSync[1] = lnk_r.startSync[0];
        lnk_nxt.strapSync[0] = busAddressStrap;
        lnk_nxt.strapSync[1] = lnk_r.strapSync[0];
        if (lnk_r.bitCnt == BYTE_BITS) begin
            lnk_nxt.bitCnt = 4'h0;
            if (!ackable) begin
                lnk_nxt.phase = LINK_IDLE;
            end else begin
                unique case (lnk_r.phase)
                    LINK_ADDR: lnk_nxt.phase = LINK_SEL;
                    LINK_SEL: begin
                        lnk_nxt.wr    = '{isData: 1'b0, sel: lnk_r.shift[3:0], data: REG_RESET};
                        lnk_nxt.wrTgl = ~lnk_r.wrTgl;
                        lnk_nxt.phase = LINK_DATA;
                    end
                    LINK_DATA: begin
                        lnk_nxt.wr    = '{isData: 1'b1, sel: lnk_r.wr.sel, data: lnk_r.shift};
                        lnk_nxt.wrTgl = ~lnk_r.wrTgl;
                        lnk_nxt.phase = LINK_SEL;
                    end
                    LINK_IDLE: lnk_nxt.phase = LINK_IDLE;
                endcase
            end
        end else begin
            lnk_nxt.shift = {lnk_r.shift[6:0], sdaIn};
            if (lnk_r.phase != LINK_IDLE) begin
                lnk_nxt.bitCnt = lnk_r.bitCnt + 4'h1;
            end
        end
        // the synchroniser costs two bus clocks, already shifted in
        if (lnk_r.startSync[1] != lnk_r.startSeen) begin
            lnk_nxt.startSeen = lnk_r.startSync[1];
            lnk_nxt.phase     = LINK_ADDR;
            lnk_nxt.bitCnt    = START_BITS;
            lnk_nxt.shift     = {lnk_r.shift[6:0], sdaIn};
        end
    end

    always_ff @(posedge scl or negedge resetn) begin
        if (!resetn) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    // acknowledge is driven low from the falling edge after the eighth bit
    always_ff @(negedge scl or negedge resetn) begin
        if (!resetn) begin
            ackOe_r <= 1'b0;
        end else begin
            ackOe_r <= (lnk_r.bitCnt == BYTE_BITS) && ackable;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe  = ackOe_r;

    // ------------------------------------------------------------------
    // core domain: registers, ramp, ambient loop, segment modulation
    // ------------------------------------------------------------------
    // the word is stable for a whole byte after its toggle, so no second copy
    assign wrEvt     = st_r.wrSync[1] != st_r.wrSeen;
    assign wrWord    = lnk_r.wr;
    assign ambActive = st_r.run && st_r.gainEn && (st_r.gain != 5'h00) && (st_r.ambTime != 6'h00)
                       && !st_r.busy && (st_r.ramp == RAMP_IDLE) && !wrEvt;

    always_comb begin
        logic [4:0] need;
        logic [6:0] ambNeed;
        logic       ambDown;
        need    = 5'h00;
        ambNeed = 7'h00;
        ambDown = 1'b0;
        st_nxt  = st_r;
        // synchronisers: the first stage only feeds the second
        st_nxt.wrSync    = {st_r.wrSync[0], lnk_r.wrTgl};
        st_nxt.wrSeen    = st_r.wrSync[1];
        st_nxt.startSync = {st_r.startSync[0], startTgl_r};
        st_nxt.startSeen = st_r.startSync[1];
        st_nxt.stopSync  = {st_r.stopSync[0], stopTgl_r};
        st_nxt.stopSeen  = st_r.stopSync[1];
        st_nxt.ambSync   = {st_r.ambSync[0], ambientSenseInput};

        // frame activity; a start in the same cycle as a stop wins
        if (st_r.startSync[1] != st_r.startSeen) begin
            st_nxt.busy = 1'b1;
        end else if (st_r.stopSync[1] != st_r.stopSeen) begin
            st_nxt.busy = 1'b0;
        end

        // step interval of the running ramp
        if (st_r.ramp == RAMP_RUN) begin
            need = (st_r.stepTime == 5'h00) ? 5'h01 : st_r.stepTime;
            st_nxt.rampPre = advanceCount(st_r.rampPre, RAMP_LAST);
            if (st_r.rampPre == RAMP_LAST) begin
                st_nxt.rampUnits = st_r.rampUnits + 5'h01;
                if (st_r.rampUnits + 5'h01 >= need) begin
                    st_nxt.rampUnits = 5'h00;
                    st_nxt.code      = stepToward(st_r.code, st_r.rampTgt);
                    if (stepToward(st_r.code, st_r.rampTgt) == st_r.rampTgt) begin
                        st_nxt.ramp = RAMP_IDLE;
                    end
                end
            end
        end

        // ambient loop: down steps take twice the up step
        ambDown = st_r.ambSync[1];
        ambNeed = ambDown ? {ambMult(st_r.ambTime), 1'b0} : {1'b0, ambMult(st_r.ambTime)};
        if (ambActive) begin
            st_nxt.ambPre = advanceCount(st_r.ambPre, AMB_LAST);
            if (st_r.ambPre == AMB_LAST) begin
                st_nxt.ambUnits = st_r.ambUnits + 7'h01;
                if (st_r.ambUnits + 7'h01 >= ambNeed) begin
                    st_nxt.ambUnits = 7'h00;
                    if (ambDown && st_r.code > {1'b0, st_r.floorCode}) begin
                        st_nxt.code = st_r.code - 5'h01;
                    end else if (!ambDown && st_r.code < st_r.maxCode) begin
                        st_nxt.code = st_r.code + 5'h01;
                    end
                end
            end
        end else begin
            // paused counters restart cleanly once the frame is over
            st_nxt.ambPre   = '0;
            st_nxt.ambUnits = 7'h00;
        end

        // register writes land at the ack of their byte
        if (wrEvt && !wrWord.isData) begin
            st_nxt.run = wrWord.sel != SEL_SHUTDOWN;
        end else if (wrEvt) begin
            unique case (wrWord.sel)
                SEL_DIRECT: begin
                    st_nxt.maxCode = wrWord.data[4:0];
                    st_nxt.code    = wrWord.data[4:0];
                    st_nxt.ramp    = RAMP_IDLE;
                end
                SEL_UP: begin
                    st_nxt.upTgt  = wrWord.data[4:0];
                    st_nxt.lastUp = 1'b1;
                end
                SEL_DOWN: begin
                    st_nxt.dnTgt  = wrWord.data[4:0];
                    st_nxt.lastUp = 1'b0;
                end
                SEL_STEP: begin
                    st_nxt.stepTime  = wrWord.data[4:0];
                    st_nxt.rampTgt   = st_r.lastUp ? st_r.upTgt : st_r.dnTgt;
                    st_nxt.rampPre   = '0;
                    st_nxt.rampUnits = 5'h00;
                    // starts from whatever code the ambient loop left behind
                    st_nxt.ramp = ((st_r.lastUp ? st_r.upTgt : st_r.dnTgt) == st_r.code) ? RAMP_IDLE
                                                                                          : RAMP_RUN;
                end
                SEL_SEG0:  st_nxt.duty[0] = wrWord.data[4:0];
                SEL_SEG1:  st_nxt.duty[1] = wrWord.data[4:0];
                SEL_SEG2:  st_nxt.duty[2] = wrWord.data[4:0];
                SEL_GAIN: begin
                    st_nxt.gainEn = wrWord.data[GAIN_EN_BIT];
                    st_nxt.gain   = wrWord.data[4:0];
                end
                SEL_FLOOR: st_nxt.floorCode = wrWord.data[3:0];
                SEL_AMBT:  st_nxt.ambTime   = wrWord.data[5:0];
                default:   st_nxt.run       = st_r.run; // unmapped selects store nothing
            endcase
        end

        // segment modulation, 32 slots per period
        st_nxt.pwmPre = (st_r.pwmPre == PWM_LAST) ? '0 : st_r.pwmPre + 1'b1;
        if (st_r.pwmPre == PWM_LAST) begin
            st_nxt.pwmSlot = st_r.pwmSlot + 5'h01;
        end
        for (int i = 0; i < 3; i++) begin
            st_nxt.segOut[i] = st_r.run && (st_r.pwmSlot < st_r.duty[i]);
        end
        st_nxt.bias = st_r.run && st_r.gainEn;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ledCurrent       = st_r.code;
    assign ledEnable        = st_r.run;
    assign segmentPwm       = st_r.segOut;
    assign sensorBiasOutput = st_r.bias;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_direct_write;
        wrEvt && wrWord.isData && wrWord.sel == SEL_DIRECT;
    endsequence

    sequence s_shutdown_select;
        wrEvt && !wrWord.isData && wrWord.sel == SEL_SHUTDOWN;
    endsequence

    property p_direct;
        @(posedge clk) disable iff (!resetn)
        s_direct_write |=> ledCurrent == $past(wrWord.data[4:0]) && st_r.ramp == RAMP_IDLE;
    endproperty
    a_direct: assert property (p_direct) else $error("direct write not applied");

    property p_step_start;
        @(posedge clk) disable iff (!resetn)
        wrEvt && wrWord.isData && wrWord.sel == SEL_STEP && st_r.lastUp && st_r.upTgt != st_r.code
        |=> st_r.ramp == RAMP_RUN && st_r.rampTgt == $past(st_r.upTgt);
    endproperty
    a_step_start: assert property (p_step_start) else $error("ramp did not start");

    property p_one_code;
        @(posedge clk) disable iff (!resetn)
        !wrEvt |=> ledCurrent == $past(ledCurrent) || ledCurrent == 5'($past(ledCurrent) + 5'h01)
                   || ledCurrent == 5'($past(ledCurrent) - 5'h01);
    endproperty
    a_one_code: assert property (p_one_code) else $error("code moved more than one step");

    property p_never_at_target;
        @(posedge clk) disable iff (!resetn)
        st_r.ramp == RAMP_RUN |-> st_r.code != st_r.rampTgt;
    endproperty
    a_never_at_target: assert property (p_never_at_target) else $error("ramp kept running at target");

    property p_amb_max;
        @(posedge clk) disable iff (!resetn)
        ambActive && st_r.code <= st_r.maxCode |=> st_r.code <= st_r.maxCode;
    endproperty
    a_amb_max: assert property (p_amb_max) else $error("ambient raised code above setting");

    property p_amb_floor;
        @(posedge clk) disable iff (!resetn)
        ambActive && st_r.code >= {1'b0, st_r.floorCode} |=> st_r.code >= {1'b0, st_r.floorCode};
    endproperty
    a_amb_floor: assert property (p_amb_floor) else $error("ambient lowered code below floor");

    property p_busy_hold;
        @(posedge clk) disable iff (!resetn)
        st_r.busy && st_r.ramp == RAMP_IDLE && !wrEvt |=> $stable(ledCurrent);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("code moved during a frame");

    property p_shutdown;
        @(posedge clk) disable iff (!resetn)
        s_shutdown_select ##1 !wrEvt |-> !ledEnable ##1 (segmentPwm == 3'h0 && !sensorBiasOutput);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown did not isolate outputs");

    property p_ack_addr;
        @(negedge scl) disable iff (!resetn)
        lnk_r.bitCnt == BYTE_BITS && lnk_r.phase == LINK_ADDR && lnk_r.shift[7:1] != ADDR_STRAP_LOW
        && lnk_r.shift[7:1] != ADDR_STRAP_HIGH |=> !sdaOe;
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("foreign address acknowledged");

endmodule : ldps_ctrl

// [logic/ldps_pkg.sv]
// shared constants and types for the led dimming and light sense controller
package ldps_pkg;

    // ------------------------------------------------------------------
    // register select codes (low nibble of the select byte)
    // ------------------------------------------------------------------
    localparam logic [3:0] SEL_SHUTDOWN = 4'h0;
    localparam logic [3:0] SEL_DIRECT   = 4'h1;
    localparam logic [3:0] SEL_UP       = 4'h2;
    localparam logic [3:0] SEL_DOWN     = 4'h3;
    localparam logic [3:0] SEL_STEP     = 4'h4;
    localparam logic [3:0] SEL_SEG0     = 4'h5;
    localparam logic [3:0] SEL_SEG1     = 4'h6;
    localparam logic [3:0] SEL_SEG2     = 4'h7;
    localparam logic [3:0] SEL_GAIN     = 4'h8;
    localparam logic [3:0] SEL_FLOOR    = 4'h9;
    localparam logic [3:0] SEL_AMBT     = 4'ha;

    // ------------------------------------------------------------------
    // bus addresses, field positions, reset values
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_STRAP_LOW  = 7'h39;
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h3a;
    localparam int         GAIN_EN_BIT     = 7;
    localparam logic [3:0] BYTE_BITS       = 4'h8;
    localparam logic [3:0] START_BITS      = 4'h3;
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam logic [4:0] CODE_MAX        = 5'h1f;

    // ------------------------------------------------------------------
    // timing: figures in microseconds, counts in clk cycles
    // ------------------------------------------------------------------
    localparam int CLK_HZ           = 25_000_000;
    localparam int RAMP_LSB_US      = 12_500;
    localparam int AMB_BASE_US      = 50_000;
    localparam int RAMP_LSB_CYC_DEF = CLK_HZ / 1_000_000 * RAMP_LSB_US;
    localparam int AMB_BASE_CYC_DEF = CLK_HZ / 1_000_000 * AMB_BASE_US;
    localparam int PWM_SLOT_CYC_DEF = 32;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       isData;
        logic [3:0] sel;
        logic [7:0] data;
    } ldps_wr_t;

    typedef enum logic [1:0] {LINK_IDLE, LINK_ADDR, LINK_SEL, LINK_DATA} ldps_phase_t;
    typedef enum logic {RAMP_IDLE, RAMP_RUN} ldps_ramp_t;

endpackage : ldps_pkg

// [tb/ldps_host.sv]
// two-wire controller model that writes select/data pairs to the device
module ldps_host (
    // link pins
    output logic     scl,
    output logic     sdaLow,
    input  wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 100ps;

    // clock stands high and data is released outside frames
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    // msb first; the ninth clock samples the ack
    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaLow = ~b[i];
            #7.5 scl = 1'b1;
            #7.5 scl = 1'b0;
        end
        sdaLow = 1'b0;
        #7.5 scl = 1'b1;
        ack = ~sdaLine;
        #7.5 scl = 1'b0;
        #300; // scl held low so the slow core sees every byte
    endtask : sendByte

    // start, address, one select/data pair, stop
    task automatic writeReg(input logic [7:0] adr, input logic [3:0] sel, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        // bus free time, so a stop and the next start stay two distinct data edges
        #15 sdaLow = 1'b1;
        #7.5 scl = 1'b0;
        sendByte(adr, a0);
        sendByte({4'h0, sel}, a1);
        sendByte(d, a2);
        sdaLow = 1'b1;
        #7.5 scl = 1'b1;
        #7.5 sdaLow = 1'b0;
        ok = a0 & a1 & a2;
    endtask : writeReg
endmodule : ldps_host

// [tb/tb_ldps_ctrl.sv]
// self-checking bench for the led dimming and light sense controller
module tb_ldps_ctrl import ldps_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, resetn, scl, sdaLow, sdaOut, sdaOe, amb, ledEnable, bias, ack, strap;
    logic [4:0] ledCurrent;
    logic [2:0] segmentPwm;
    wire sdaLine = ~(sdaLow | (sdaOe & ~sdaOut)); // pulled up
    int errors = 0;
    int checks = 0;
    logic [7:0] duty [3] = '{8'h08, 8'he0, 8'h1f};

    ldps_ctrl #(.RAMP_LSB_CYC(8), .AMB_BASE_CYC(8), .PWM_SLOT_CYC(2)) u_dut (.clk(clk), .resetn(resetn),
        .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .busAddressStrap(strap),
        .ambientSenseInput(amb), .ledCurrent(ledCurrent), .ledEnable(ledEnable),
        .segmentPwm(segmentPwm), .sensorBiasOutput(bias));
    ldps_host u_host (.scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // one frame to the strapped address, then let the core settle
    task automatic wr(input logic [3:0] sel, input logic [7:0] d);
        u_host.writeReg(8'h72, sel, d, ack);
        check({7'h0, ack}, 8'h01);
        repeat (8) @(posedge clk);
        #1;
    endtask : wr

    // bounded wait for a code, counting the moves and the cycles between them;
    // the first gap seen is partial, so only later gaps are compared
    task automatic waitCode(input logic [4:0] want, input int moves, input int per);
        logic [4:0] last;
        int n;
        int gap;
        last = ledCurrent;
        n = 0;
        gap = 0;
        for (int i = 0; i < 4000 && ledCurrent !== want; i++) begin
            @(posedge clk);
            #1;
            gap++;
            if (ledCurrent !== last) begin
                n++;
                if (n > 1) check(8'(gap), 8'(per));
                gap = 0;
            end
            last = ledCurrent;
        end
        if (ledCurrent !== want) begin
            errors++;
            $display("CHECK FAILED at %0t: code wait ran out", $time);
            summarize();
        end
        check(8'(n), 8'(moves));
    endtask : waitCode

    initial begin
        int hi;
        resetn = 1'b0;
        amb = 1'b0;
        strap = 1'b0;
        repeat (3) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge clk);
        #1 check({ledEnable, bias, 1'b0, ledCurrent}, 8'h00);
        u_host.writeReg(8'h76, SEL_DIRECT, 8'h1f, ack);
        check({7'h0, ack}, 8'h00);
        u_host.writeReg(8'h73, SEL_DIRECT, 8'hea, ack);
        repeat (8) @(posedge clk);
        #1 check({ledEnable, 2'h0, ledCurrent}, 8'h8a);
        $display("test access done");
        wr(SEL_UP, 8'hed);
        wr(SEL_STEP, 8'h00);
        waitCode(5'h0d, 2, 8);
        wr(SEL_DOWN, 8'h05);
        wr(SEL_STEP, 8'he4);
        waitCode(5'h05, 8, 32);
        $display("test ramp done");
        for (int s = 0; s < 3; s++) begin
            wr(SEL_SEG0 + 4'(s), duty[s]);
            hi = 0;
            repeat (64) begin
                @(posedge clk);
                #1 hi += int'(segmentPwm[s]);
            end
            check(8'(hi), {2'h0, duty[s][4:0], 1'b0});
        end
        $display("test segment done");
        wr(SEL_FLOOR, 8'hf3);
        wr(SEL_AMBT, 8'h01);
        amb = 1'b1;
        wr(SEL_GAIN, 8'h81);
        check({7'h0, bias}, 8'h01);
        waitCode(5'h03, 2, 16);
        repeat (100) @(posedge clk);
        #1 check({3'h0, ledCurrent}, 8'h03);
        amb = 1'b0;
        waitCode(5'h0a, 7, 8);
        repeat (100) @(posedge clk);
        #1 check({3'h0, ledCurrent}, 8'h0a);
        $display("test ambient done");
        wr(SEL_SHUTDOWN, 8'h00);
        check({ledEnable, bias, 3'h0, segmentPwm}, 8'h00);
        strap = 1'b1;
        u_host.writeReg(8'h72, SEL_SEG0, 8'h00, ack);
        check({7'h0, ack}, 8'h00);
        u_host.writeReg(8'h75, SEL_DIRECT, 8'h07, ack);
        check({7'h0, ack}, 8'h01);
        repeat (8) @(posedge clk);
        #1 check({ledEnable, 2'h0, ledCurrent}, 8'h87);
        $display("test shutdown done");
        summarize();
    end
endmodule : tb_ldps_ctrl
